// ===== src/pc_card_host_port.sv
// Card host port: strap capture, strobe sync, register/buffer decode.
// Assumes clock_i is the bus interface clock and the display
// buffer arbiter answers mem_req_o with a one-cycle mem_ack_i.
`timescale 1ns/1ps
`include "host_port_cfg.svh"
module pc_card_host_port #(
  parameter logic [7:0] ID_CODE = 8'h5a  // Arbitrary value
) (
  input wire logic clock_i,              // Bus interface clock
  input wire logic rst_n_i,              // Sync reset, active low
  input wire logic [15:0] cfg_straps_i,  // Configuration straps
  input wire logic chip_select_n_i,      // Chip select
  input wire logic mem_reg_sel_i,        // 1 buffer, 0 registers
  input wire logic high_byte_enable_n_i, // From card enable 2
  input wire logic low_byte_enable_n_i,  // From card enable 1
  input wire logic read_strobe_n_i,      // From output enable
  input wire logic write_strobe_n_i,     // From write enable
  input wire logic bus_start_n_i,        // Held high, no function
  input wire logic [20:0] host_addr_in_i, // Card address
  input wire logic [15:0] host_data_bus_i, // Data pins in
  output logic [15:0] host_data_bus_o,   // Data pins out
  output logic host_data_bus_oe_o,       // Data pins driven
  output logic hold_off_o,               // Wait level
  output logic hold_off_oe_o,            // Wait pin driven
  input wire logic refresh_busy_i,       // Display owns registers
  output logic mem_req_o,                // Buffer request
  output logic mem_we_o,                 // Buffer write
  output logic [19:0] mem_addr_o,        // Buffer word address
  output logic [1:0] mem_be_o,           // Buffer byte enables
  output logic [15:0] mem_wdata_o,       // Buffer write data
  input wire logic [15:0] mem_rdata_i,   // Buffer read data
  input wire logic mem_ack_i,            // Buffer done pulse
  output logic pccard_mode_o,            // Card mode selected
  output logic little_endian_o,          // Endian strap
  output logic alt_if_o,                 // Alternate variant
  output logic clk_halved_o,             // Clock halving on
  output logic reg_locked_o              // Select bit 7 set
);

  // Synchronised pin levels
  logic [42:0] pin_lvl;
  logic [15:0] strap_lvl;
  logic cs_n_s;
  logic mr_s;
  logic hbe_n_s;
  logic lbe_n_s;
  logic rd_n_s;
  logic wr_n_s;
  logic [20:0] addr_s;
  logic [15:0] data_s;

  // Captured configuration
  logic [15:0] strap_ff;
  logic mode_ok_ff;

  // Access state
  host_port_pkg::hp_state_t state_ff;
  host_port_pkg::hp_state_t nxt_state;
  logic acc_rd_ff;
  logic acc_we_ff;
  logic [1:0] acc_be_ff;
  logic [19:0] acc_word_ff;
  logic [15:0] acc_data_ff;
  logic [15:0] rd_word_ff;
  logic [7:0] misc_ff;
  logic tick_ff;
  logic mem_req_ff;
  logic hold_off_ff;
  logic hold_off_oe_ff;
  logic [15:0] dout_ff;
  logic dout_oe_ff;

  // Decode wires
  logic sel;
  logic rd_act;
  logic wr_act;
  logic [1:0] be_act;
  logic [1:0] be_int;
  logic [15:0] wdata_int;
  logic start;
  logic strobe_gone;
  logic en;
  logic [4:0] widx;
  logic word0;
  logic lo_ok;
  logic hi_ok;
  logic word_ok;
  logic reg_go;
  logic [1:0] reg_we;
  logic misc_we;
  logic [15:0] reg_rdata;
  logic [15:0] reg_word;
  logic wait_act;
  logic [15:0] host_word;

  pin_sync #(
    .WIDTH(43)
  ) u_pin_sync (
    .clock_i(clock_i),
    .pin_i({chip_select_n_i, mem_reg_sel_i, high_byte_enable_n_i,
            low_byte_enable_n_i, read_strobe_n_i, write_strobe_n_i,
            host_addr_in_i, host_data_bus_i}),
    .level_o(pin_lvl)
  );

  pin_sync #(
    .WIDTH(`HP_STRAP_W)
  ) u_strap_sync (
    .clock_i(clock_i),
    .pin_i(cfg_straps_i),
    .level_o(strap_lvl)
  );

  // Split synchronised bundle
  assign cs_n_s = pin_lvl[42];
  assign mr_s = pin_lvl[41];
  assign hbe_n_s = pin_lvl[40];
  assign lbe_n_s = pin_lvl[39];
  assign rd_n_s = pin_lvl[38];
  assign wr_n_s = pin_lvl[37];
  assign addr_s = pin_lvl[36:16];
  assign data_s = pin_lvl[15:0];

  // track straps while reset is low, freeze at release
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      strap_ff <= strap_lvl;
    end
  end

  // card mode only with field 111
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      mode_ok_ff <= 1'b0;
    end else begin
      mode_ok_ff <= (strap_ff[`HP_MODE_MSB:`HP_MODE_LSB] == `HP_MODE_PCCARD);
    end
  end

  // single clock, rated to 50 MHz
  // one-cycle enable, every other edge when halved
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      tick_ff <= 1'b0;
    end else begin
      tick_ff <= ~tick_ff;
    end
  end
  assign en = ~strap_ff[`HP_HALVE_BIT] | tick_ff;

  // Bus start pin left unread, it has no use in card mode
  // selected only while chip select low in card mode
  assign sel = mode_ok_ff & ~cs_n_s;
  // strobes follow output and write enables
  assign rd_act = ~rd_n_s;
  assign wr_act = ~wr_n_s;
  // either enable low activates its lane
  assign be_act = ~{hbe_n_s, lbe_n_s};
  assign be_int = strap_ff[`HP_ENDIAN_BIT] ? be_act : {be_act[0], be_act[1]};
  assign wdata_int = strap_ff[`HP_ENDIAN_BIT] ? data_s : {data_s[7:0], data_s[15:8]};
  // Both strobes together is ignored as illegal
  assign start = sel & (rd_act ^ wr_act) & (|be_act);
  assign strobe_gone = ~sel | ~(rd_act | wr_act) | ~(|be_act);

  // word index wraps every 64 bytes
  assign widx = acc_word_ff[4:0];
  assign word0 = (widx == 5'h00);
  // only the first 47 bytes exist
  assign lo_ok = ({widx, 1'b0} < `HP_REG_BYTES);
  assign hi_ok = ({widx, 1'b1} < `HP_REG_BYTES);
  // only offsets 000h and 001h while locked
  assign word_ok = ~misc_ff[`HP_LOCK_BIT] | word0;

  // register access waits out display refresh
  assign reg_go = (state_ff == host_port_pkg::ST_REG) & en & ~refresh_busy_i;
  // offset 000h read-only, 001h holds the select bit
  assign misc_we = reg_go & ~acc_rd_ff & word0 & acc_be_ff[1];
  // Write lanes trimmed to the bytes that exist
  assign reg_we = (reg_go & ~acc_rd_ff & word_ok & ~word0) ?
                  (acc_be_ff & {hi_ok, lo_ok}) : 2'b00;

  // Register words, read data one edge after the index
  reg_mem #(
    .AW(`HP_REG_WORD_W)
  ) u_reg_mem (
    .clock_i(clock_i),
    .addr_i(widx),
    .we_i(reg_we),
    .wdata_i(acc_data_ff),
    .rdata_o(reg_rdata)
  );

  // Register read word, absent bytes read zero
  assign reg_word = word0 ? {misc_ff, ID_CODE} :
                    (word_ok ? (reg_rdata & {{8{hi_ok}}, {8{lo_ok}}}) : 16'h0000);

  // Next state of the access sequencer
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      host_port_pkg::ST_IDLE: begin
        if (en && start) begin
          nxt_state = mr_s ? host_port_pkg::ST_MEM : host_port_pkg::ST_REG;
        end
      end
      host_port_pkg::ST_REG: begin
        if (reg_go) begin
          nxt_state = acc_rd_ff ? host_port_pkg::ST_REG_RD : host_port_pkg::ST_DONE;
        end
      end
      host_port_pkg::ST_REG_RD: begin
        nxt_state = host_port_pkg::ST_DONE;
      end
      host_port_pkg::ST_MEM: begin
        // Ack checked every edge so a halved clock cannot miss it
        if (mem_ack_i) begin
          nxt_state = host_port_pkg::ST_DONE;
        end
      end
      host_port_pkg::ST_DONE: begin
        if (en && strobe_gone) begin
          nxt_state = host_port_pkg::ST_IDLE;
        end
      end
      default: begin
        nxt_state = host_port_pkg::ST_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      state_ff <= host_port_pkg::ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // latch request; address bit zero dropped, lanes from enables
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      acc_rd_ff <= 1'b0;
      acc_we_ff <= 1'b1;
      acc_be_ff <= 2'b00;
      acc_word_ff <= 20'h00000;
      acc_data_ff <= 16'h0000;
    end else if (state_ff == host_port_pkg::ST_IDLE && en && start) begin
      acc_rd_ff <= rd_act;
      acc_we_ff <= wr_act;
      acc_be_ff <= be_int;
      acc_word_ff <= addr_s[20:1];
      acc_data_ff <= wdata_int;
    end
  end

  // select bit set at reset, cleared by software
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      misc_ff <= `HP_MISC_RST;
    end else if (misc_we) begin
      misc_ff <= acc_data_ff[15:8];
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      mem_req_ff <= 1'b0;
    end else if (state_ff == host_port_pkg::ST_IDLE && en && start && mr_s) begin
      mem_req_ff <= 1'b1;
    end else if (mem_ack_i) begin
      mem_req_ff <= 1'b0;
    end
  end

  // Read word captured from registers or buffer
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      rd_word_ff <= 16'h0000;
    end else if (state_ff == host_port_pkg::ST_REG_RD) begin
      rd_word_ff <= reg_word;
    end else if (state_ff == host_port_pkg::ST_MEM && mem_ack_i && acc_rd_ff) begin
      rd_word_ff <= mem_rdata_i;
    end
  end

  // present read data in the strapped byte order
  assign host_word = strap_ff[`HP_ENDIAN_BIT] ? rd_word_ff :
                     {rd_word_ff[7:0], rd_word_ff[15:8]};

  // drive data only while a read is finished and still strobed
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      dout_ff <= 16'h0000;
      dout_oe_ff <= 1'b0;
    end else begin
      dout_ff <= host_word;
      dout_oe_ff <= (state_ff == host_port_pkg::ST_DONE) & acc_rd_ff & sel & rd_act;
    end
  end

  // hold off from strobe until the transfer is done
  assign wait_act = sel & (rd_act | wr_act) & (|be_act) &
                    (state_ff != host_port_pkg::ST_DONE);

  // polarity strap; drive strap sets the enable
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      hold_off_ff <= 1'b0;
      hold_off_oe_ff <= 1'b0;
    end else begin
      hold_off_ff <= strap_ff[`HP_WAITPOL_BIT] ? wait_act : ~wait_act;
      hold_off_oe_ff <= strap_ff[`HP_WDRIVE_BIT] | sel;
    end
  end

  // Outputs straight from flops
  // data pins wired straight
  assign host_data_bus_o = dout_ff;
  assign host_data_bus_oe_o = dout_oe_ff;
  assign hold_off_o = hold_off_ff;
  assign hold_off_oe_o = hold_off_oe_ff;
  assign mem_req_o = mem_req_ff;
  assign mem_we_o = acc_we_ff;
  assign mem_addr_o = acc_word_ff;
  assign mem_be_o = acc_be_ff;
  assign mem_wdata_o = acc_data_ff;
  // alternate variant flag for the rest of the host logic
  assign alt_if_o = strap_ff[`HP_ALTIF_BIT];
  assign pccard_mode_o = mode_ok_ff;
  assign little_endian_o = strap_ff[`HP_ENDIAN_BIT];
  assign clk_halved_o = strap_ff[`HP_HALVE_BIT];
  assign reg_locked_o = misc_ff[`HP_LOCK_BIT];

endmodule

// ===== include/host_port_cfg.svh
// Strap positions, codes and address map of the card host port.
// Assumes straps and card strobes arrive as asynchronous pins.
// Notes on behaviour
// - Address and data pins wire straight to the card address and data lines.
// - Endian strap 1 gives little endian, 0 big; card use needs little.
// - Memory/register select steers each access to registers or display buffer.
// - High byte enable follows card enable 2, low follows card enable 1.
// - Read strobe follows output enable, write strobe follows write enable.
// - Hold-off stays asserted until read data valid or write data accepted.
// - Wait polarity strap 1 makes hold-off active high, 0 active low.
// - All sixteen straps captured at reset rise, applied after release.
// - Bus mode strap field 111 selects card host operation.
// - Alternate interface strap 1 picks alternate variant, 0 the primary.
// - Clock halving strap 1 divides bus clock by two, 0 undivided.
// - Wait drive strap 1 drives hold-off always, 0 floats when unselected.
// - Port works with bus clock up to 50 MHz.
// - Select low decodes 0 to 1FFFFFh to the 47-byte register set.
// - Select high decodes 200000h to 3FFFFFh to the 2M-byte buffer.
// - Registers repeat every 64 bytes; upper card address bits ignored.
// - After reset select bit 7 of 001h reads 1; only 000h, 001h reachable.
// - Card address bit zero unused; byte lanes come from byte enables.
`ifndef HOST_PORT_CFG_SVH
`define HOST_PORT_CFG_SVH
`define HP_STRAP_W 16
`define HP_MODE_MSB 3
`define HP_MODE_LSB 1
`define HP_MODE_PCCARD 3'h7
`define HP_ENDIAN_BIT 4
`define HP_WAITPOL_BIT 5
`define HP_ALTIF_BIT 11
`define HP_HALVE_BIT 12
`define HP_WDRIVE_BIT 15
`define HP_REG_BYTES 6'h2f
`define HP_REG_WORD_W 5
`define HP_MISC_RST 8'h80
`define HP_LOCK_BIT 7
`define HP_BUS_CLK_MAX_MHZ 50
`define HP_CLK_MHZ 25
`endif

// ===== include/host_port_pkg.sv
// Types shared by the card host port modules.
// Assumes the cfg header supplies all numbers.
package host_port_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_REG,
    ST_REG_RD,
    ST_MEM,
    ST_DONE
  } hp_state_t;
endpackage

// ===== src/pin_sync.sv
// Three-stage synchroniser for asynchronous pins.
// Assumes inputs are levels; output moves only when stages two and three agree.
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clock_i,             // Bus interface clock
  input wire logic [WIDTH-1:0] pin_i,   // Asynchronous pins
  output logic [WIDTH-1:0] level_o      // Filtered level
);
  logic [WIDTH-1:0] s1_ff;
  logic [WIDTH-1:0] s2_ff;
  logic [WIDTH-1:0] s3_ff;
  logic [WIDTH-1:0] lvl_ff;

  // Shift chain; no reset so straps flow through while reset is held
  always_ff @(posedge clock_i) begin
    s1_ff <= pin_i;
    s2_ff <= s1_ff;
    s3_ff <= s2_ff;
  end

  // Per-bit agreement filter
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge clock_i) begin
      if (s2_ff[i] == s3_ff[i]) begin
        lvl_ff[i] <= s3_ff[i];
      end
    end
  end

  assign level_o = lvl_ff;
endmodule

// ===== src/reg_mem.sv
// Small word store for the register set, two byte lanes.
// Assumes one access per cycle; read data registered.
`timescale 1ns/1ps
module reg_mem #(
  parameter int AW = 5
) (
  input wire logic clock_i,          // Bus interface clock
  input wire logic [AW-1:0] addr_i,  // Word index
  input wire logic [1:0] we_i,       // Byte write enables
  input wire logic [15:0] wdata_i,   // Write data
  output logic [15:0] rdata_o        // Registered read data
);
  logic [15:0] mem [0:(1<<AW)-1];
  logic [15:0] rdata_ff;

  // Lane writes and registered read
  always_ff @(posedge clock_i) begin
    if (we_i[0]) begin
      mem[addr_i][7:0] <= wdata_i[7:0];
    end
    if (we_i[1]) begin
      mem[addr_i][15:8] <= wdata_i[15:8];
    end
    rdata_ff <= mem[addr_i];
  end

  assign rdata_o = rdata_ff;
endmodule

// ===== testbench/pc_card_host_port_sva.sv
// Port checker for the card host port, watching its top ports only.
// Assumes straps change only while reset is held low.
`timescale 1ns/1ps
`include "host_port_cfg.svh"
module host_port_sva (
  input wire logic clock_i, // Bus clock
  input wire logic rst_n_i, // Sync reset
  input wire logic [15:0] cfg_straps_i, // Straps
  input wire logic chip_select_n_i, // Chip select
  input wire logic mem_reg_sel_i, // Buffer select
  input wire logic low_byte_enable_n_i, // Low lane
  input wire logic read_strobe_n_i, // Read strobe
  input wire logic write_strobe_n_i, // Write strobe
  input wire logic [20:0] host_addr_in_i, // Card address
  input wire logic host_data_bus_oe_o, // Data driven
  input wire logic hold_off_o, // Wait level
  input wire logic hold_off_oe_o, // Wait driven
  input wire logic mem_req_o, // Buffer request
  input wire logic mem_we_o, // Buffer write
  input wire logic [19:0] mem_addr_o, // Buffer address
  input wire logic mem_ack_i, // Buffer done
  input wire logic pccard_mode_o, // Card mode
  input wire logic little_endian_o, // Endian
  input wire logic alt_if_o, // Alternate
  input wire logic clk_halved_o, // Halved clock
  input wire logic reg_locked_o // Lock bit
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  // Active level of the wait output
  wire logic pol = cfg_straps_i[`HP_WAITPOL_BIT];
  wire logic drv = cfg_straps_i[`HP_WDRIVE_BIT];
  // Steps of a transfer
  sequence s_rel; $rose(rst_n_i); endsequence
  sequence s_ack; mem_req_o && mem_ack_i; endsequence
  sequence s_idle; (pccard_mode_o && read_strobe_n_i && write_strobe_n_i)[*6]; endsequence
  sequence s_rd;
    pccard_mode_o && !chip_select_n_i && !low_byte_enable_n_i && write_strobe_n_i
      && $fell(read_strobe_n_i);
  endsequence
  property p_mode;
    s_rel |=> pccard_mode_o == (cfg_straps_i[`HP_MODE_MSB:`HP_MODE_LSB] == `HP_MODE_PCCARD);
  endproperty
  a_mode: assert property (p_mode) else $error("mode flag wrong");
  property p_endian; s_rel |=> little_endian_o == cfg_straps_i[`HP_ENDIAN_BIT]; endproperty
  a_endian: assert property (p_endian) else $error("endian flag wrong");
  property p_alt_half;
    s_rel |=> alt_if_o == cfg_straps_i[`HP_ALTIF_BIT] && clk_halved_o == cfg_straps_i[`HP_HALVE_BIT];
  endproperty
  a_alt_half: assert property (p_alt_half) else $error("alt or halve flag wrong");
  property p_lock; s_rel |-> reg_locked_o; endproperty
  a_lock: assert property (p_lock) else $error("lock clear after reset");
  property p_drive; pccard_mode_o && $past(pccard_mode_o) && drv |-> hold_off_oe_o; endproperty
  a_drive: assert property (p_drive) else $error("wait not driven");
  property p_float; (pccard_mode_o && !drv && chip_select_n_i)[*6] |-> !hold_off_oe_o; endproperty
  a_float: assert property (p_float) else $error("wait driven unselected");
  property p_idle; s_idle |-> hold_off_o == !pol; endproperty
  a_idle: assert property (p_idle) else $error("wait active while idle");
  property p_wait; s_rd |-> ##[3:8] hold_off_o == pol; endproperty
  a_wait: assert property (p_wait) else $error("no wait on read");
  property p_oe_rd; read_strobe_n_i[*6] |-> !host_data_bus_oe_o; endproperty
  a_oe_rd: assert property (p_oe_rd) else $error("data driven without read");
  property p_oe_late; host_data_bus_oe_o |-> hold_off_o == !pol; endproperty
  a_oe_late: assert property (p_oe_late) else $error("data driven while waiting");
  property p_reg_only; (!mem_reg_sel_i)[*6] |-> !$rose(mem_req_o); endproperty
  a_reg_only: assert property (p_reg_only) else $error("buffer hit by register access");
  property p_addr; mem_req_o |-> mem_addr_o == host_addr_in_i[20:1]; endproperty
  a_addr: assert property (p_addr) else $error("buffer address wrong");
  property p_dir; $rose(mem_req_o) |-> mem_we_o == !write_strobe_n_i; endproperty
  a_dir: assert property (p_dir) else $error("buffer direction wrong");
  property p_hold; mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o); endproperty
  a_hold: assert property (p_hold) else $error("request dropped early");
  property p_ack; s_ack |=> !mem_req_o ##1 hold_off_o == !pol; endproperty
  a_ack: assert property (p_ack) else $error("no release after ack");
endmodule
bind pc_card_host_port host_port_sva u_sva (
  .clock_i(clock_i), .rst_n_i(rst_n_i), .cfg_straps_i(cfg_straps_i),
  .chip_select_n_i(chip_select_n_i), .mem_reg_sel_i(mem_reg_sel_i),
  .low_byte_enable_n_i(low_byte_enable_n_i), .read_strobe_n_i(read_strobe_n_i),
  .write_strobe_n_i(write_strobe_n_i), .host_addr_in_i(host_addr_in_i),
  .host_data_bus_oe_o(host_data_bus_oe_o), .hold_off_o(hold_off_o),
  .hold_off_oe_o(hold_off_oe_o), .mem_req_o(mem_req_o), .mem_we_o(mem_we_o),
  .mem_addr_o(mem_addr_o), .mem_ack_i(mem_ack_i), .pccard_mode_o(pccard_mode_o),
  .little_endian_o(little_endian_o), .alt_if_o(alt_if_o), .clk_halved_o(clk_halved_o),
  .reg_locked_o(reg_locked_o));

// ===== testbench/buffer_model.sv
// Display buffer arbiter model answering the port's buffer requests.
// Assumes requests hold steady until the one-cycle acknowledge.
`timescale 1ns/1ps
module buffer_model (
  input wire logic clock_i, // Bus clock
  input wire logic req_i, // Buffer request
  input wire logic we_i, // Write
  input wire logic [19:0] addr_i, // Word address
  input wire logic [1:0] be_i, // Byte enables
  input wire logic [15:0] wdata_i, // Write data
  output logic ack_o = 1'b0, // Done pulse
  output logic [15:0] rdata_o = 16'h0 // Read data
);
  logic [15:0] mem [logic [19:0]];
  logic [15:0] cur;
  int wait_q = 0;
  // Random latency stands in for refresh contention
  always @(posedge clock_i) begin
    cur = mem.exists(addr_i) ? mem[addr_i] : 16'h0;
    if (req_i && !ack_o && wait_q == 0) begin
      if (we_i) begin
        mem[addr_i] = {be_i[1] ? wdata_i[15:8] : cur[15:8], be_i[0] ? wdata_i[7:0] : cur[7:0]};
      end
      ack_o <= 1'b1;
      rdata_o <= cur;
      wait_q <= $urandom_range(3, 0);
    end else begin
      ack_o <= 1'b0;
      rdata_o <= ~rdata_o; // Garbage outside the acknowledge
      if (req_i && !ack_o) begin
        wait_q <= wait_q - 1;
      end
    end
  end
endmodule

// ===== testbench/pc_card_host_port_bench.sv
// Self-checking bench for the card host port with a buffer model.
// Assumes the design answers through the wait pin and data pins.
`timescale 1ns/1ps
`include "host_port_cfg.svh"
module pc_card_host_port_bench;
  localparam logic [7:0] ID = 8'h5a; // Arbitrary value
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [15:0] cfg_straps_i = 16'h801e;
  logic chip_select_n_i = 1'b1;
  logic mem_reg_sel_i = 1'b0;
  logic high_byte_enable_n_i = 1'b1;
  logic low_byte_enable_n_i = 1'b1;
  logic read_strobe_n_i = 1'b1;
  logic write_strobe_n_i = 1'b1;
  logic bus_start_n_i = 1'b1;
  logic [20:0] host_addr_in_i = 21'h0;
  logic [15:0] host_d = 16'h0;
  logic refresh_busy_i = 1'b0;
  logic [15:0] host_data_bus_o, mem_wdata_o, mem_rdata_i;
  logic host_data_bus_oe_o, hold_off_o, hold_off_oe_o, mem_req_o, mem_we_o, mem_ack_i;
  logic [19:0] mem_addr_o;
  logic [1:0] mem_be_o;
  logic pccard_mode_o, little_endian_o, alt_if_o, clk_halved_o, reg_locked_o;
  int num_errors = 0;
  int n_checks = 0;
  // Data wire: the port when it drives, else the host
  wire logic [15:0] host_data_bus_i = host_data_bus_oe_o ? host_data_bus_o : host_d;
  wire logic pol = cfg_straps_i[`HP_WAITPOL_BIT];
  pc_card_host_port #(.ID_CODE(ID)) u_dut (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .cfg_straps_i(cfg_straps_i),
    .chip_select_n_i(chip_select_n_i), .mem_reg_sel_i(mem_reg_sel_i),
    .high_byte_enable_n_i(high_byte_enable_n_i), .low_byte_enable_n_i(low_byte_enable_n_i),
    .read_strobe_n_i(read_strobe_n_i), .write_strobe_n_i(write_strobe_n_i),
    .bus_start_n_i(bus_start_n_i), .host_addr_in_i(host_addr_in_i),
    .host_data_bus_i(host_data_bus_i), .host_data_bus_o(host_data_bus_o),
    .host_data_bus_oe_o(host_data_bus_oe_o), .hold_off_o(hold_off_o),
    .hold_off_oe_o(hold_off_oe_o), .refresh_busy_i(refresh_busy_i), .mem_req_o(mem_req_o),
    .mem_we_o(mem_we_o), .mem_addr_o(mem_addr_o), .mem_be_o(mem_be_o),
    .mem_wdata_o(mem_wdata_o), .mem_rdata_i(mem_rdata_i), .mem_ack_i(mem_ack_i),
    .pccard_mode_o(pccard_mode_o), .little_endian_o(little_endian_o), .alt_if_o(alt_if_o),
    .clk_halved_o(clk_halved_o), .reg_locked_o(reg_locked_o));
  buffer_model u_buf (.clock_i(clock_i), .req_i(mem_req_o), .we_i(mem_we_o),
    .addr_i(mem_addr_o), .be_i(mem_be_o), .wdata_i(mem_wdata_o), .ack_o(mem_ack_i),
    .rdata_o(mem_rdata_i));
  always #20 clock_i = ~clock_i;
  // Random refresh contention on the register set
  always @(posedge clock_i) refresh_busy_i <= 1'($urandom);
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("Checks %0d, errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Lanes kept where the enable stays high
  function automatic logic [15:0] merge(input logic [15:0] o, n, input logic [1:0] en_n);
    merge = {en_n[1] ? o[15:8] : n[15:8], en_n[0] ? o[7:0] : n[7:0]};
  endfunction
  // reset as the inverted socket reset
  // straps held well before and after release
  task automatic do_reset(input logic [15:0] s);
    @(posedge clock_i);
    rst_n_i <= 1'b0;
    cfg_straps_i <= s;
    repeat (6) @(posedge clock_i);
    rst_n_i <= 1'b1;
    repeat (8) @(posedge clock_i);
  endtask
  task automatic wait_ho(input logic v);
    int t;
    t = 0;
    while (hold_off_o !== v && t < 300) begin
      @(negedge clock_i);
      t++;
    end
    chk(16'(hold_off_o), 16'(v));
  endtask
  // one card cycle, pins held until wait releases
  task automatic acc(input logic wr, sel, input logic [20:0] a, input logic [1:0] en_n,
      input logic [15:0] wd, output logic [15:0] rd);
    @(posedge clock_i);
    chip_select_n_i <= 1'b0;
    mem_reg_sel_i <= sel;
    host_addr_in_i <= a;
    {high_byte_enable_n_i, low_byte_enable_n_i} <= en_n;
    host_d <= wr ? wd : ~host_d;
    write_strobe_n_i <= !wr;
    read_strobe_n_i <= wr;
    @(negedge clock_i);
    wait_ho(pol);
    wait_ho(!pol);
    @(negedge clock_i);
    rd = host_data_bus_i;
    chk(16'(host_data_bus_oe_o), 16'(!wr));
    @(posedge clock_i);
    chip_select_n_i <= 1'b1;
    {write_strobe_n_i, read_strobe_n_i} <= 2'b11;
    {high_byte_enable_n_i, low_byte_enable_n_i} <= 2'b11;
    host_d <= ~host_d;
    repeat (8) @(posedge clock_i);
  endtask
  initial begin
    #800000;
    num_errors++;
    end_of_test();
  end
  initial begin
    logic [15:0] rd, d1, d2;
    logic [20:0] a, b;
    logic [1:0] en;
    void'($urandom(32'h1024));
    do_reset(16'h801e);
    chk(16'({pccard_mode_o, little_endian_o, alt_if_o, clk_halved_o}), 16'h000c);
    chk(16'(reg_locked_o), 16'h1);
    acc(1'b0, 1'b0, 21'h0, 2'b00, 16'h0, rd);
    chk(rd, {`HP_MISC_RST, ID});
    acc(1'b1, 1'b0, 21'h10, 2'b00, 16'h1234, rd);
    acc(1'b0, 1'b0, 21'h10, 2'b00, 16'h0, rd);
    chk(rd, 16'h0);
    acc(1'b1, 1'b0, 21'h0, 2'b01, 16'h0000, rd);
    chk(16'(reg_locked_o), 16'h0);
    // register upper bits and buffer bit zero not decoded, so aliases answer
    // Registers then buffer: full write, then full or single-lane write at an alias
    for (int s = 0; s < 2; s++) begin
      for (int i = 0; i < 6; i++) begin
        a = s ? 21'($urandom) : {15'($urandom), 5'($urandom_range(22, 1)), 1'($urandom)};
        b = s ? a ^ 21'h1 : {15'($urandom), a[5:0]};
        d1 = 16'($urandom);
        d2 = 16'($urandom);
        en = 2'($urandom_range(2, 0));
        acc(1'b1, 1'(s), a, 2'b00, d1, rd);
        acc(1'b1, 1'(s), b, en, d2, rd);
        acc(1'b0, 1'(s), b, 2'b00, 16'h0, rd);
        chk(rd, merge(d1, d2, en));
      end
    end
    // same offset, register and buffer kept apart
    acc(1'b1, 1'b0, 21'h20, 2'b00, 16'ha5c3, rd);
    acc(1'b1, 1'b1, 21'h20, 2'b00, 16'h3c5a, rd);
    acc(1'b0, 1'b0, 21'h20, 2'b00, 16'h0, rd);
    chk(rd, 16'ha5c3);
    acc(1'b0, 1'b1, 21'h20, 2'b00, 16'h0, rd);
    chk(rd, 16'h3c5a);
    // Byte 47 lies past the register set
    acc(1'b1, 1'b0, 21'h2e, 2'b00, 16'h6b7c, rd);
    acc(1'b0, 1'b0, 21'h2e, 2'b00, 16'h0, rd);
    chk(rd, 16'h007c);
    do_reset(16'h801a);
    chk(16'(pccard_mode_o), 16'h0);
    // Big endian, active-high wait, floating wait, halved clock
    do_reset(16'h182e);
    chk(16'({pccard_mode_o, little_endian_o, alt_if_o, clk_halved_o}), 16'h000b);
    chk(16'(hold_off_oe_o), 16'h0);
    acc(1'b0, 1'b0, 21'h0, 2'b00, 16'h0, rd);
    chk(rd, {ID, `HP_MISC_RST});
    end_of_test();
  end
endmodule
